// ==== hdl/xpc_consts.vh ====
// Purpose: Constants for the crosspoint control port host controller.
// Assumes: 250 MHz system clock, 32-bit APB register bus.
// Notes: Times are in ns; cycle counts are derived in the main module.
`ifndef XPC_CONSTS_VH
`define XPC_CONSTS_VH

`define XPC_CLK_NS 4
`define XPC_SETUP_NS 8
`define XPC_STROBE_NS 20
`define XPC_HOLD_NS 8
`define XPC_RESET_NS 100

`define XPC_OFF_CMD 12'h000
`define XPC_OFF_TARGET 12'h004
`define XPC_OFF_STATUS 12'h008

`define XPC_OP_WRITE 2'h0
`define XPC_OP_UPDATE 2'h1
`define XPC_OP_READ 2'h2
`define XPC_OP_RESET 2'h3

`define XPC_BANK_BIT 6
`define XPC_NUM_MSB 5
`define XPC_DATA_LSB 8
`define XPC_DATA_MSB 13
`define XPC_ST_BUSY 0
`define XPC_ST_ERR 1
`define XPC_ST_PRIMED 2

`define XPC_NUM_OUTPUTS 34
`define XPC_LAST_OUTPUT 6'h21
`define XPC_BROADCAST 6'h3f
`define XPC_CYC_ONE 8'h01

`endif

// ==== hdl/xpc_phase_timer.v ====
// Purpose: Counts the cycles of one bus phase of the crosspoint controller.
// Assumes: load_val is at least one.
// Notes: last is high in the final cycle of a phase of load_val cycles.
`timescale 1ns/1ps
`include "xpc_consts.vh"
module xpc_phase_timer (
  input wire clk,
  input wire resetn,
  input wire load,
  input wire [7:0] load_val,
  output wire last
);
  reg [7:0] count_reg;
  reg [7:0] count_next;

  always @* begin
    count_next = count_reg;
    if (load) begin
      count_next = load_val;
    end else if (count_reg != 8'h00) begin
      count_next = count_reg - `XPC_CYC_ONE;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= 8'h00;
    end else begin
      count_reg <= count_next;
    end
  end

  assign last = (count_reg == `XPC_CYC_ONE);
endmodule // xpc_phase_timer

// ==== hdl/xpc_host.v ====
// Purpose: Host controller that drives the parallel control pins of a 34x34 crosspoint.
// Assumes: APB slave with zero wait states; device pins sampled synchronously.
// Notes: Each command except reset runs setup, strobe and hold phases on the device pins; reset runs the device reset phase.
`timescale 1ns/1ps
`include "xpc_consts.vh"
module xpc_host (
  input wire clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  output reg [6:0] output_number_field,
  output reg [5:0] config_word_pins_out,
  output reg config_word_pins_oe,
  input wire [5:0] config_word_pins_in,
  output reg write_strobe_n,
  output reg transfer_strobe_n,
  output reg readback_enable_n,
  output reg chip_select_n,
  output reg device_reset_n
);
  localparam integer SETUP_RAW = (`XPC_SETUP_NS + `XPC_CLK_NS - 1) / `XPC_CLK_NS;
  localparam integer STROBE_RAW = (`XPC_STROBE_NS + `XPC_CLK_NS - 1) / `XPC_CLK_NS;
  localparam integer HOLD_RAW = (`XPC_HOLD_NS + `XPC_CLK_NS - 1) / `XPC_CLK_NS;
  localparam integer RESET_RAW = (`XPC_RESET_NS + `XPC_CLK_NS - 1) / `XPC_CLK_NS;
  localparam [7:0] SETUP_CYC = SETUP_RAW[7:0];
  localparam [7:0] STROBE_CYC = STROBE_RAW[7:0];
  localparam [7:0] HOLD_CYC = HOLD_RAW[7:0];
  localparam [7:0] RESET_CYC = RESET_RAW[7:0];

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_SETUP = 3'h1;
  localparam [2:0] ST_STROBE = 3'h2;
  localparam [2:0] ST_HOLD = 3'h3;
  localparam [2:0] ST_RESET = 3'h4;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [1:0] op_reg;
  reg [6:0] target_addr_reg;
  reg [5:0] target_data_reg;
  reg [5:0] readback_reg;
  reg err_reg;
  reg boot_reg;
  reg [33:0] conn_mask_reg;
  reg [33:0] cur_mask_reg;
  reg timer_load;
  reg [7:0] timer_val;
  wire phase_last;
  wire apb_write;
  wire apb_setup;
  wire cmd_write;
  wire [5:0] num;
  wire addr_ok;
  wire cmd_ok;
  wire primed;
  wire [33:0] hit_mask;
  wire [33:0] one_hot;

  assign pready = 1'b1;
  assign apb_write = psel & penable & pwrite;
  assign apb_setup = psel & ~penable;
  assign cmd_write = apb_write & (paddr == `XPC_OFF_CMD);
  assign num = target_addr_reg[`XPC_NUM_MSB:0];
  // Writes need a real output or the broadcast code, reads a real output; update and reset accept any target.
  assign addr_ok = (num <= `XPC_LAST_OUTPUT) | (num == `XPC_BROADCAST);
  assign cmd_ok = (pwdata[1:0] == `XPC_OP_UPDATE) | (pwdata[1:0] == `XPC_OP_RESET) |
                  (addr_ok & ~((pwdata[1:0] == `XPC_OP_READ) &
                  (num == `XPC_BROADCAST)));
  assign one_hot = {33'h0_0000_0000, 1'b1} << num;
  assign hit_mask = (num == `XPC_BROADCAST) ? {34{1'b1}} : one_hot;
  assign primed = (&conn_mask_reg) & (&cur_mask_reg);

  xpc_phase_timer u_timer (
    .clk(clk),
    .resetn(resetn),
    .load(timer_load),
    .load_val(timer_val),
    .last(phase_last)
  );

  always @* begin
    state_next = state_reg;
    timer_load = 1'b0;
    timer_val = SETUP_CYC;
    case (state_reg)
      ST_IDLE: begin
        if (cmd_write & cmd_ok) begin
          timer_load = 1'b1;
          if (pwdata[1:0] == `XPC_OP_RESET) begin
            state_next = ST_RESET;
            timer_val = RESET_CYC;
          end else begin
            state_next = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        if (phase_last) begin
          state_next = ST_STROBE;
          timer_load = 1'b1;
          timer_val = STROBE_CYC;
        end
      end
      ST_STROBE: begin
        if (phase_last) begin
          state_next = ST_HOLD;
          timer_load = 1'b1;
          timer_val = HOLD_CYC;
        end
      end
      ST_HOLD: begin
        if (phase_last) begin
          state_next = ST_IDLE;
        end
      end
      ST_RESET: begin
        // The first cycle after reset arms the timer of the power-up device reset.
        if (boot_reg) begin
          timer_load = 1'b1;
          timer_val = RESET_CYC;
        end else if (phase_last) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_RESET;
      op_reg <= `XPC_OP_RESET;
      target_addr_reg <= 7'h00;
      target_data_reg <= 6'h00;
      readback_reg <= 6'h00;
      err_reg <= 1'b0;
      boot_reg <= 1'b1;
      conn_mask_reg <= 34'h0_0000_0000;
      cur_mask_reg <= 34'h0_0000_0000;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      state_reg <= state_next;
      boot_reg <= 1'b0;
      if (state_reg == ST_IDLE && cmd_write) begin
        op_reg <= pwdata[1:0];
      end
      if (apb_write && paddr == `XPC_OFF_TARGET && state_reg == ST_IDLE) begin
        target_addr_reg <= pwdata[6:0];
        target_data_reg <= pwdata[`XPC_DATA_MSB:`XPC_DATA_LSB];
      end
      // A refused command sets the error flag even when it is cleared in the same cycle.
      if (cmd_write && (state_reg != ST_IDLE || !cmd_ok)) begin
        err_reg <= 1'b1;
      end else if (apb_write && paddr == `XPC_OFF_STATUS && pwdata[`XPC_ST_ERR]) begin
        err_reg <= 1'b0;
      end
      if (state_reg == ST_STROBE && phase_last && op_reg == `XPC_OP_READ) begin
        readback_reg <= config_word_pins_in;
      end
      if (state_reg == ST_STROBE && phase_last && op_reg == `XPC_OP_WRITE) begin
        if (target_addr_reg[`XPC_BANK_BIT]) begin
          cur_mask_reg <= cur_mask_reg | hit_mask;
        end else begin
          conn_mask_reg <= conn_mask_reg | hit_mask;
        end
      end
      if (state_reg == ST_RESET) begin
        conn_mask_reg <= {34{1'b1}};
        cur_mask_reg <= {34{1'b1}};
      end
      if (apb_setup) begin
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
        if (paddr == `XPC_OFF_TARGET) begin
          prdata <= {18'h0_0000, target_data_reg, 1'b0, target_addr_reg};
        end else if (paddr == `XPC_OFF_STATUS) begin
          prdata <= {18'h0_0000, readback_reg, 5'h00, primed, err_reg,
                     state_reg != ST_IDLE};
        end else if (paddr != `XPC_OFF_CMD) begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Pin drivers: all strobes are levels held across the whole strobe phase.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      output_number_field <= 7'h00;
      config_word_pins_out <= 6'h00;
      config_word_pins_oe <= 1'b0;
      write_strobe_n <= 1'b1;
      transfer_strobe_n <= 1'b1;
      readback_enable_n <= 1'b1;
      chip_select_n <= 1'b1;
      device_reset_n <= 1'b0;
    end else begin
      output_number_field <= target_addr_reg;
      config_word_pins_out <= target_data_reg;
      device_reset_n <= (state_next != ST_RESET);
      chip_select_n <= ~((state_next == ST_SETUP) | (state_next == ST_STROBE) |
                         (state_next == ST_HOLD));
      config_word_pins_oe <= (state_next != ST_IDLE) & (state_next != ST_RESET) &
                             (op_reg == `XPC_OP_WRITE || state_reg == ST_IDLE) &
                             ~(state_reg == ST_IDLE & cmd_write &
                             pwdata[1:0] != `XPC_OP_WRITE);
      write_strobe_n <= ~((state_next == ST_STROBE) & (op_reg == `XPC_OP_WRITE));
      transfer_strobe_n <= ~((state_next == ST_STROBE) & (op_reg == `XPC_OP_UPDATE));
      readback_enable_n <= ~((state_next == ST_STROBE) & (op_reg == `XPC_OP_READ));
    end
  end
endmodule // xpc_host

// ==== verification/xpc_host_chk.sv ====
// Purpose: Pin protocol checks on the crosspoint host controller.
// Assumes: Single clock domain, asynchronous active-low reset.
// Notes: Attached to the controller by bind.
`timescale 1ns/1ps
module xpc_host_chk (
  input wire clk,
  input wire resetn,
  input wire [6:0] output_number_field,
  input wire config_word_pins_oe,
  input wire write_strobe_n,
  input wire transfer_strobe_n,
  input wire readback_enable_n,
  input wire chip_select_n,
  input wire device_reset_n
);
  wire any_strobe = !write_strobe_n || !transfer_strobe_n || !readback_enable_n;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence held_low(logic s);
    (!s)[*5] ##1 s;
  endsequence
  we_pulse_a: assert property ($fell(write_strobe_n) |-> held_low(write_strobe_n))
    else $error("write strobe width wrong");
  upd_pulse_a: assert property ($fell(transfer_strobe_n) |-> held_low(transfer_strobe_n))
    else $error("transfer strobe width wrong");
  cs_gate_a: assert property (any_strobe |-> !chip_select_n)
    else $error("strobe without chip select");
  re_over_we_a: assert property (!(!readback_enable_n && !write_strobe_n))
    else $error("readback and write together");
  re_release_a: assert property (!readback_enable_n |-> !config_word_pins_oe)
    else $error("data driven in readback");
  we_drive_a: assert property (!write_strobe_n |->
    config_word_pins_oe && $stable(output_number_field))
    else $error("write pins not held");
  cs_hold_a: assert property ($rose(write_strobe_n) |->
    (!chip_select_n)[*2] ##1 chip_select_n)
    else $error("hold phase wrong");
  addr_ok_a: assert property (!write_strobe_n |->
    output_number_field[5:0] <= 6'h21 || output_number_field[5:0] == 6'h3f)
    else $error("write to reserved code");
  rb_addr_a: assert property (!readback_enable_n |-> output_number_field[5:0] <= 6'h21)
    else $error("readback of reserved or broadcast");
  dev_reset_a: assert property ($fell(device_reset_n) |-> ##1 (!device_reset_n)[*8])
    else $error("device reset too short");
endmodule // xpc_host_chk
bind xpc_host xpc_host_chk u_chk (.clk(clk), .resetn(resetn),
  .output_number_field(output_number_field),
  .config_word_pins_oe(config_word_pins_oe), .write_strobe_n(write_strobe_n),
  .transfer_strobe_n(transfer_strobe_n), .readback_enable_n(readback_enable_n),
  .chip_select_n(chip_select_n), .device_reset_n(device_reset_n));

// ==== verification/xpc_dev_model.sv ====
// Purpose: Behavioural model of the crosspoint control port.
// Assumes: Pins change only on clock edges, so levels are sampled per cycle.
// Notes: Bank 0 holds connection codes, bank 1 current codes.
`timescale 1ns/1ps
module xpc_dev_model (
  input wire clk,
  input wire rst_n,
  input wire cs_n,
  input wire we_n,
  input wire upd_n,
  input wire re_n,
  input wire [6:0] addr,
  input wire [5:0] data,
  output wire [5:0] rb_data,
  output wire rb_oe
);
  logic [5:0] r1 [0:1][0:33];
  logic [5:0] r2 [0:1][0:33];
  wire hit = addr[5:0] < 6'h22;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 34; i++) begin
        r1[0][i] <= 6'h3f;
        r2[0][i] <= 6'h3f;
        r1[1][i] <= 6'h07;
        r2[1][i] <= 6'h07;
      end
    end else if (!cs_n) begin
      for (int i = 0; i < 34; i++) begin
        if (!upd_n) begin
          r2[0][i] <= r1[0][i];
          r2[1][i] <= r1[1][i];
        end
        if (!we_n && re_n && (addr[5:0] == 6'h3f || addr[5:0] == i)) begin
          r1[addr[6]][i] <= addr[6] ? {2'b00, data[3:0]} : data;
        end
      end
    end
  end
  assign rb_oe = !cs_n && !re_n && hit;
  assign rb_data = rb_oe ? r2[addr[6]][addr[5:0]] : 6'h00;
endmodule // xpc_dev_model

// ==== verification/tb_crosspoint_control_port.sv ====
// Purpose: Self-checking bench of the crosspoint host controller.
// Assumes: Device model on the pins, APB master in the bench.
// Notes: A released data bus shows a toggling pattern.
`timescale 1ns/1ps
`include "xpc_consts.vh"
module tb_crosspoint_control_port;
  logic clk = 0;
  logic resetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [5:0] float_v = 6'h15;
  logic [31:0] r;
  logic e;
  int errors = 0;
  int total_checks = 0;
  wire pready, pslverr, oe, we_n, upd_n, re_n, cs_n, drst_n, rb_oe;
  wire [31:0] prdata;
  wire [6:0] addr;
  wire [5:0] dout, rb;
  wire [5:0] bus = oe ? dout : (rb_oe ? rb : float_v);
  initial forever #2 clk = ~clk;
  always @(posedge clk) float_v <= ~float_v;
  xpc_host u_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .output_number_field(addr), .config_word_pins_out(dout), .config_word_pins_oe(oe),
    .config_word_pins_in(bus), .write_strobe_n(we_n), .transfer_strobe_n(upd_n),
    .readback_enable_n(re_n), .chip_select_n(cs_n), .device_reset_n(drst_n));
  xpc_dev_model u_dev (.clk(clk), .rst_n(drst_n), .cs_n(cs_n), .we_n(we_n), .upd_n(upd_n),
    .re_n(re_n), .addr(addr), .data(bus), .rb_data(rb), .rb_oe(rb_oe));
  task report_and_stop;
    $display("checks=%0d mismatches=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task cmp32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin errors++; report_and_stop; end
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wait_idle;
    int n;
    n = 0;
    r = 32'h0000_0001;
    while (r[0] !== 1'b0 && n < 100) begin apb(0, `XPC_OFF_STATUS, 32'h0000_0000); n++; end
    if (n >= 100) begin errors++; report_and_stop; end
  endtask
  task cmd(input logic [1:0] op, input logic [6:0] a, input logic [5:0] d);
    apb(1, `XPC_OFF_TARGET, {18'h0_0000, d, 1'b0, a});
    apb(1, `XPC_OFF_CMD, {30'h0000_0000, op});
    wait_idle;
  endtask
  task readback(input logic [6:0] a, input logic [5:0] exp);
    cmd(2'h2, a, 6'h00);
    cmp32(32'(r[13:8]), 32'(exp));
  endtask
  task err_is(input logic v);
    apb(0, `XPC_OFF_STATUS, 32'h0000_0000);
    cmp32(32'(r[1]), 32'(v));
    apb(1, `XPC_OFF_STATUS, 32'h0000_0002);
  endtask
  task t_after_reset;
    wait_idle;
    cmp32(32'(r[2]), 32'h0000_0001);
    readback(7'h05, 6'h3f);
    readback(7'h45, 6'h07);
    $display("test after_reset done");
  endtask
  task t_two_rank;
    cmd(2'h0, 7'h00, 6'h21);
    cmd(2'h0, 7'h61, 6'h3a);
    apb(0, `XPC_OFF_TARGET, 32'h0000_0000);
    cmp32(r, 32'h0000_3a61);
    readback(7'h00, 6'h3f);
    cmd(2'h1, 7'h00, 6'h00);
    readback(7'h00, 6'h21);
    readback(7'h61, 6'h0a);
    $display("test two_rank done");
  endtask
  task t_broadcast;
    cmd(2'h0, 7'h3f, 6'h11);
    cmd(2'h0, 7'h7f, 6'h02);
    cmd(2'h1, 7'h00, 6'h00);
    readback(7'h14, 6'h11);
    readback(7'h61, 6'h02);
    $display("test broadcast done");
  endtask
  task t_reserved;
    cmd(2'h0, 7'h22, 6'h05);
    err_is(1'b1);
    err_is(1'b0);
    cmd(2'h2, 7'h3f, 6'h00);
    err_is(1'b1);
    cmd(2'h1, 7'h00, 6'h00);
    readback(7'h21, 6'h11);
    apb(0, 12'h00c, 32'h0000_0000);
    cmp32(32'(e), 32'h0000_0001);
    cmp32(r, 32'h0000_0000);
    $display("test reserved done");
  endtask
  task t_dev_reset;
    cmd(2'h3, 7'h00, 6'h00);
    readback(7'h14, 6'h3f);
    cmd(2'h1, 7'h00, 6'h00);
    readback(7'h14, 6'h3f);
    readback(7'h61, 6'h07);
    $display("test dev_reset done");
  endtask
  task t_host_reset;
    cmd(2'h0, 7'h14, 6'h09);
    cmd(2'h0, 7'h54, 6'h03);
    cmd(2'h1, 7'h00, 6'h00);
    resetn <= 0;
    repeat (6) @(posedge clk);
    resetn <= 1;
    wait_idle;
    cmp32(32'(r[2]), 32'h0000_0001);
    readback(7'h14, 6'h3f);
    readback(7'h54, 6'h07);
    $display("test host_reset done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1;
    t_after_reset;
    t_two_rank;
    t_broadcast;
    t_reserved;
    t_dev_reset;
    t_host_reset;
    report_and_stop;
  end
endmodule // tb_crosspoint_control_port
